// *** src/psf_regs.vh ***
// register offsets, field positions and reset values of the program status word block
`ifndef PSF_REGS_VH
`define PSF_REGS_VH

// ==========================================
// register byte offsets
`define PSF_OFF_STATUS_WORD 8'hD0
`define PSF_OFF_ALU_CTRL 8'hD4
`define PSF_OFF_ALU_OPS 8'hD8
`define PSF_OFF_ALU_RESULT 8'hDC
`define PSF_OFF_ACC 8'hE0
`define PSF_OFF_BANK_BASE 8'hE4
`define PSF_OFF_WREG_IDX 8'hE8
`define PSF_OFF_WREG_DATA 8'hEC

// ==========================================
// status word bit positions
`define PSF_BIT_CARRY 7
`define PSF_BIT_AUX 6
`define PSF_BIT_UF0 5
`define PSF_BIT_BANK_HI 4
`define PSF_BIT_BANK_LO 3
`define PSF_BIT_OVF 2
`define PSF_BIT_UF1 1
`define PSF_BIT_PAR 0

// ==========================================
// alu op codes (alu control bits 3:0)
`define PSF_OP_ADD 4'h0
`define PSF_OP_ADDC 4'h1
`define PSF_OP_SUBB 4'h2
`define PSF_OP_ANL_C 4'h3
`define PSF_OP_ORL_C 4'h4
`define PSF_OP_CPL_C 4'h5
`define PSF_OP_MOV_C 4'h6
`define PSF_OP_CLR_C 4'h7
`define PSF_OP_SETB_C 4'h8

// ==========================================
// reset values and bus answers
`define PSF_RST_STATUS 8'h00
`define PSF_RST_ACC 8'h00
`define PSF_RESP_OKAY 2'h0
`define PSF_RESP_SLVERR 2'h2

`endif

// *** src/psf_bank_mem.v ***
// four-bank working register store, registered read port
`timescale 1ns/1ps
`default_nettype none

module psf_bank_mem #(
    parameter AW = 5,
    parameter DW = 8
) (
    input wire clk, // core clock
    input wire we, // write strobe
    input wire [AW-1:0] waddr, // write address
    input wire [DW-1:0] wdata, // write data
    input wire [AW-1:0] raddr, // read address
    output reg [DW-1:0] rdata // registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

`default_nettype wire

// *** src/psf_top.v ***
// program status word logic with alu flag generation, over an axi4-lite slave
// Notes on behaviour
// RQ1 - carry set on carry out of msb
// RQ2 - carry is boolean bit accumulator
// RQ3 - aux carry from nibble boundary carry
// RQ4 - overflow when bit6 and bit7 carries differ
// RQ5 - parity follows accumulator odd count
// RQ6 - two user flags, software only
// RQ7 - bank select places bank at 8*bank
// RQ8 - status writes store all but parity
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module psf_top (
    input wire aclk, // core clock, 20 MHz
    input wire aresetn, // synchronous reset, active low
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output reg [7:0] status_word_q, // status word to the core
    output reg [4:0] bank_base_q // base address of the active bank
);
    // ==========================================
    // functions
    function [7:0] lane0;
        input [31:0] d;
        input [3:0] s;
        input [7:0] old;
        begin
            lane0 = s[0] ? d[7:0] : old;
        end
    endfunction

    function [2:0] addc8;
        // returns {carry7, carry3, carry6} for a + b + cin
        input [7:0] a;
        input [7:0] b;
        input cin;
        reg [4:0] lo;
        reg [7:0] mid;
        reg [8:0] full;
        begin
            lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            addc8 = {full[8], lo[4], mid[7]};
        end
    endfunction

    // ==========================================
    // state
    reg [7:0] acc_q;
    reg [7:0] op_a_q;
    reg [7:0] op_b_q;
    reg [7:0] result_q;
    reg bit_in_q;
    reg [7:0] flags_q; // bits 7..1 stored, bit 0 unused
    reg [7:0] wr_addr_q;
    reg [31:0] wr_data_q;
    reg [3:0] wr_strb_q;
    reg aw_have_q;
    reg w_have_q;
    reg rd_pend_q;
    reg [7:0] rd_addr_q;
    reg [2:0] wreg_idx_q;

    wire parity_w = ^acc_q; // [RQ5]
    wire [7:0] status_w = {flags_q[7:1], parity_w};

    // ==========================================
    // write channel capture, either order
    wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire [3:0] op_w = wr_data_q[3:0];
    wire op_start = wr_go && wr_addr_q == `PSF_OFF_ALU_CTRL && wr_strb_q[0];
    wire st_wr = wr_go && wr_addr_q == `PSF_OFF_STATUS_WORD;

    wire [7:0] sub_b = ~op_b_q;
    wire sub_mode = (op_w == `PSF_OP_SUBB);
    wire [7:0] add_b = sub_mode ? sub_b : op_b_q;
    wire add_cin = (op_w == `PSF_OP_ADD) ? 1'b0 :
                   (sub_mode ? ~flags_q[`PSF_BIT_CARRY] : flags_q[`PSF_BIT_CARRY]);
    wire [2:0] cv = addc8(op_a_q, add_b, add_cin);
    wire [7:0] sum_w = op_a_q + add_b + {7'h00, add_cin};
    wire [7:0] st_lane = lane0(wr_data_q, wr_strb_q, flags_q);

    // ==========================================
    // working registers: the bank select picks which eight of the 32 bytes are seen
    // read data lag the address by one cycle; a read racing a bank switch may see the old bank
    wire [4:0] wreg_addr = {flags_q[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO], wreg_idx_q}; // [RQ7]
    wire wreg_we = wr_go && wr_addr_q == `PSF_OFF_WREG_DATA && wr_strb_q[0];
    wire [7:0] wreg_rdata;

    psf_bank_mem #(
        .AW(5),
        .DW(8)
    ) u_bank_mem (
        .clk(aclk), // core clock
        .we(wreg_we), // store strobe
        .waddr(wreg_addr), // bank and index
        .wdata(wr_data_q[7:0]), // lane 0 only
        .raddr(wreg_addr), // same location read back
        .rdata(wreg_rdata) // registered
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSF_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 32'h00000000;
            wr_strb_q <= 4'h0;
            flags_q <= `PSF_RST_STATUS;
            acc_q <= `PSF_RST_ACC;
            op_a_q <= 8'h00;
            op_b_q <= 8'h00;
            result_q <= 8'h00;
            bit_in_q <= 1'b0;
            wreg_idx_q <= 3'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_data_q <= s_axi_wdata;
                wr_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wr_addr_q)
                    `PSF_OFF_STATUS_WORD, `PSF_OFF_ALU_CTRL, `PSF_OFF_ALU_OPS,
                    `PSF_OFF_ACC, `PSF_OFF_WREG_IDX, `PSF_OFF_WREG_DATA: begin
                        s_axi_bresp <= `PSF_RESP_OKAY;
                    end
                    `PSF_OFF_ALU_RESULT, `PSF_OFF_BANK_BASE: begin
                        s_axi_bresp <= `PSF_RESP_OKAY; // read-only, write ignored
                    end
                    default: begin
                        s_axi_bresp <= `PSF_RESP_SLVERR;
                    end
                endcase
            end
            // parity is never stored; it is recomputed from the accumulator
            if (st_wr) begin
                flags_q[7:1] <= st_lane[7:1]; // [RQ8] [RQ6] [RQ7]
            end
            if (wr_go && wr_addr_q == `PSF_OFF_ACC && wr_strb_q[0]) begin
                acc_q <= wr_data_q[7:0];
            end
            // index is kept across bank switches
            if (wr_go && wr_addr_q == `PSF_OFF_WREG_IDX && wr_strb_q[0]) begin
                wreg_idx_q <= wr_data_q[2:0];
            end
            if (wr_go && wr_addr_q == `PSF_OFF_ALU_OPS) begin
                op_a_q <= lane0(wr_data_q, wr_strb_q, op_a_q);
                if (wr_strb_q[1]) begin
                    op_b_q <= wr_data_q[15:8];
                end
                if (wr_strb_q[2]) begin
                    bit_in_q <= wr_data_q[16];
                end
            end
            // user flags and bank select are not touched here
            if (op_start) begin
                case (op_w)
                    `PSF_OP_ADD, `PSF_OP_ADDC, `PSF_OP_SUBB: begin
                        result_q <= sum_w;
                        acc_q <= sum_w;
                        // subtract reports borrow, the inverted carry
                        flags_q[`PSF_BIT_CARRY] <= cv[2] ^ sub_mode; // [RQ1]
                        flags_q[`PSF_BIT_AUX] <= cv[1] ^ sub_mode; // [RQ3]
                        flags_q[`PSF_BIT_OVF] <= cv[2] ^ cv[0]; // [RQ4]
                    end
                    `PSF_OP_ANL_C: begin
                        flags_q[`PSF_BIT_CARRY] <= flags_q[`PSF_BIT_CARRY] & bit_in_q; // [RQ2]
                    end
                    `PSF_OP_ORL_C: begin
                        flags_q[`PSF_BIT_CARRY] <= flags_q[`PSF_BIT_CARRY] | bit_in_q; // [RQ2]
                    end
                    `PSF_OP_CPL_C: begin
                        flags_q[`PSF_BIT_CARRY] <= ~flags_q[`PSF_BIT_CARRY]; // [RQ2]
                    end
                    `PSF_OP_MOV_C: begin
                        flags_q[`PSF_BIT_CARRY] <= bit_in_q; // [RQ2]
                    end
                    `PSF_OP_CLR_C: begin
                        flags_q[`PSF_BIT_CARRY] <= 1'b0; // [RQ2]
                    end
                    `PSF_OP_SETB_C: begin
                        flags_q[`PSF_BIT_CARRY] <= 1'b1; // [RQ2]
                    end
                    default: begin
                        result_q <= result_q;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // outputs to the core
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_word_q <= `PSF_RST_STATUS;
            bank_base_q <= 5'h00;
        end else begin
            status_word_q <= status_w; // [RQ5]
            bank_base_q <= {status_w[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO], 3'h0}; // [RQ7]
        end
    end

    // ==========================================
    // read channel: one cycle to register, data the next
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PSF_RESP_OKAY;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            s_axi_arready <= !rd_pend_q && !s_axi_rvalid && !s_axi_arready
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend_q <= 1'b1;
                rd_addr_q <= s_axi_araddr;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_pend_q && !s_axi_rvalid) begin
                rd_pend_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PSF_RESP_OKAY;
                case (rd_addr_q)
                    `PSF_OFF_STATUS_WORD: s_axi_rdata <= {24'h000000, status_w};
                    `PSF_OFF_ALU_CTRL: s_axi_rdata <= 32'h00000000;
                    `PSF_OFF_ALU_OPS: s_axi_rdata <= {15'h0000, bit_in_q, op_b_q, op_a_q};
                    `PSF_OFF_ALU_RESULT: s_axi_rdata <= {24'h000000, result_q};
                    `PSF_OFF_ACC: s_axi_rdata <= {24'h000000, acc_q};
                    `PSF_OFF_WREG_IDX: s_axi_rdata <= {29'h0000000, wreg_idx_q};
                    `PSF_OFF_WREG_DATA: s_axi_rdata <= {24'h000000, wreg_rdata};
                    `PSF_OFF_BANK_BASE: s_axi_rdata <= {27'h0000000,
                        status_w[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO], 3'h0};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `PSF_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/psf_top_sva.sv ***
// assertion checker for the program status word block
`timescale 1ns/1ps
`default_nettype none
module psf_top_sva (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic [7:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic [7:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic s_axi_rvalid, // r valid
    input wire logic [7:0] status_word_q, // status out
    input wire logic [4:0] bank_base_q // bank base out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // cycles since the last write beat; flags may only move shortly after one
    logic [3:0] since_wr_q;
    logic [3:0] since_wr_d;
    assign since_wr_d = (s_axi_wvalid && s_axi_wready) ? 4'h0 :
        ((since_wr_q == 4'hF) ? 4'hF : since_wr_q + 4'h1);
    always @(posedge aclk) begin
        if (!aresetn) since_wr_q <= 4'hF;
        else since_wr_q <= since_wr_d;
    end
    // ==========================================
    // bus sequences
    sequence s_aw(a);
        s_axi_awvalid && s_axi_awready && s_axi_awaddr == a;
    endsequence
    sequence s_ar(a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    a_resp_status: assert property (s_aw(8'hD0) |-> ##[1:6]
        (s_axi_bvalid && s_axi_bresp == 2'h0)) else $error("status write not okay");
    a_resp_unmapped: assert property (s_aw(8'hF0) |-> ##[1:6]
        (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("unmapped write not refused");
    a_rd_unmapped: assert property (s_ar(8'hF0) |-> ##2
        (s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)) else $error("bad read");
    a_rd_status: assert property (s_ar(8'hD0) |-> ##2
        (s_axi_rvalid && s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0)) else $error("rd");
    a_user_flag_src: assert property (!$stable({status_word_q[5], status_word_q[1]})
        |-> since_wr_q < 4'h9) else $error("user flag moved by hardware");
    a_status_cause: assert property (!$stable(status_word_q) |-> since_wr_q < 4'h9)
        else $error("status moved without a write");
    a_bank_align: assert property (bank_base_q == {status_word_q[4:3], 3'h0})
        else $error("bank base not eight times bank select");
    a_bank_match: assert property ($stable(status_word_q) [*3] |->
        bank_base_q == {status_word_q[4:3], 3'h0}) else $error("bank base mismatch");
endmodule
bind psf_top psf_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .status_word_q(status_word_q), .bank_base_q(bank_base_q));
`default_nettype wire

// *** verification/psf_top_test.sv ***
// self-checking bench for the program status word block
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"
module psf_top_test;
    typedef struct packed {
        logic [7:0] init;
        logic [3:0] op;
        logic [7:0] a;
        logic [7:0] b;
        logic bit_in;
        logic [7:0] acc;
        logic [7:0] program_status_word;
    } psf_row_t;
    localparam logic [1:0] ok = `PSF_RESP_OKAY;
    localparam logic [7:0] sw = `PSF_OFF_STATUS_WORD;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, got;
    logic [3:0] wstrb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] status;
    wire logic [4:0] bank;
    int err_total = 0;
    int check_count = 0;
    // parity column is left 0 here; the loop derives it from the acc column
    psf_row_t rows [10] = '{
        '{8'hA2, `PSF_OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80, 8'h66},
        '{8'h98, `PSF_OP_ADDC, 8'hFF, 8'h00, 1'b0, 8'h00, 8'hD8},
        '{8'h00, `PSF_OP_SUBB, 8'h00, 8'h01, 1'b0, 8'hFF, 8'hC0},
        '{8'h80, `PSF_OP_SUBB, 8'h80, 8'h00, 1'b0, 8'h7F, 8'h44},
        '{8'h80, `PSF_OP_ANL_C, 8'h00, 8'h00, 1'b0, 8'h7F, 8'h00},
        '{8'h00, `PSF_OP_ORL_C, 8'h00, 8'h00, 1'b1, 8'h7F, 8'h80},
        '{8'h80, `PSF_OP_CPL_C, 8'h00, 8'h00, 1'b0, 8'h7F, 8'h00},
        '{8'h00, `PSF_OP_MOV_C, 8'h00, 8'h00, 1'b1, 8'h7F, 8'h80},
        '{8'hE6, `PSF_OP_CLR_C, 8'h00, 8'h00, 1'b0, 8'h7F, 8'h66},
        '{8'h00, `PSF_OP_SETB_C, 8'h00, 8'h00, 1'b0, 8'h7F, 8'h80}};
    psf_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .status_word_q(status), .bank_base_q(bank));
    always #25 aclk = ~aclk;
    // ==========================================
    // bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        got = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(sw, {24'h0, rows[i].init}, ok);
            wr(`PSF_OFF_ALU_OPS, {15'h0, rows[i].bit_in, rows[i].b, rows[i].a}, ok);
            wr(`PSF_OFF_ALU_CTRL, {28'h0, rows[i].op}, ok);
            rd(`PSF_OFF_ACC, ok);
            chk("acc", {24'h0, rows[i].acc}, got);
            rd(`PSF_OFF_ALU_RESULT, ok);
            chk("result", {24'h0, rows[i].acc}, got);
            rd(sw, ok);
            chk("status", {24'h0, rows[i].program_status_word[7:1], ^rows[i].acc}, got);
        end
        wr(`PSF_OFF_WREG_IDX, 32'h05, ok);
        for (int k = 0; k < 4; k++) begin
            wr(sw, {27'h0, k[1:0], 3'h0}, ok);
            wr(`PSF_OFF_WREG_DATA, 32'hA0 + k, ok);
            rd(`PSF_OFF_BANK_BASE, ok);
            chk("bank_read", {27'h0, k[1:0], 3'h0}, got);
            chk("bank_port", {27'h0, k[1:0], 3'h0}, {27'h0, bank});
        end
        // each bank must hold its own byte at the same index
        for (int k = 0; k < 4; k++) begin
            wr(sw, {27'h0, k[1:0], 3'h0}, ok);
            rd(`PSF_OFF_WREG_DATA, ok);
            chk("bank_reg", 32'hA0 + k, got);
        end
        // written parity must lose to the accumulator
        wr(`PSF_OFF_ACC, 32'h01, ok);
        wr(sw, 32'hFE, ok);
        rd(sw, ok);
        chk("parity_set", 32'hFF, got);
        chk("status_port", 32'hFF, {24'h0, status});
        wr(`PSF_OFF_ACC, 32'h03, ok);
        wr(sw, 32'h01, ok);
        rd(sw, ok);
        chk("parity_clr", 32'h00, got);
        // lane 0 strobe off: the status word must not move
        wstrb <= 4'hE;
        wr(sw, 32'hFE, ok);
        wstrb <= 4'hF;
        rd(sw, ok);
        chk("strb_masked", 32'h00, got);
        wr(8'hF0, 32'hFF, `PSF_RESP_SLVERR);
        rd(8'hF0, `PSF_RESP_SLVERR);
        chk("unmapped", 32'h0, got);
        wr(sw, 32'hFA, ok);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sw, ok);
        chk("rst_status", {24'h0, `PSF_RST_STATUS}, got);
        chk("rst_bank", 32'h0, {27'h0, bank});
        final_report();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
